// ==== design/aimx_consts.vh ====
// constants for the converter input-select and result-format slice
// assumes a 20 MHz system clock and an ahb-lite register window
`ifndef AIMX_CONSTS_VH
`define AIMX_CONSTS_VH

// register byte offsets
`define AIMX_OFS_SEL 8'h00
`define AIMX_OFS_CTRL 8'h04
`define AIMX_OFS_RESULT 8'h08
`define AIMX_OFS_STATUS 8'h0C

// selection register layout
`define AIMX_SEL_W 6
`define AIMX_SEL_RST 6'h00

// control register bits
`define AIMX_CTRL_START 0
`define AIMX_CTRL_DONE 1
`define AIMX_CTRL_EN 2
`define AIMX_CTRL_IREF 3
`define AIMX_CTRL_GAIN_LO 4
`define AIMX_CTRL_GAIN_HI 5

// status register bits
`define AIMX_STAT_BUSY 6
`define AIMX_STAT_SETTLED 7
`define AIMX_STAT_DIFF 8
`define AIMX_STAT_TEMP_OK 9

// selection code groups and special codes
`define AIMX_GRP_SINGLE 2'h0
`define AIMX_GRP_DIFF 2'h1
`define AIMX_GRP_SAME 2'h2
`define AIMX_GRP_SWAP 2'h3
`define AIMX_LAST_PIN 4'hB
`define AIMX_CODE_TEMP 6'h0C
`define AIMX_SAME_LAST 4'h9
`define AIMX_SAME_HI_LAST 4'hD

// gains
`define AIMX_GAIN_X1 7'h01
`define AIMX_GAIN_X20 7'h14
`define AIMX_GAIN_X100 7'h64

// result limits
`define AIMX_DIFF_MAX 10'h1FF
`define AIMX_DIFF_MIN 10'h200
`define AIMX_SE_MAX 10'h3FF

// settling time of the internal reference
`define AIMX_CLK_KHZ 20000
`define AIMX_SETTLE_US 1000
`define AIMX_SETTLE_CYC ((`AIMX_SETTLE_US * `AIMX_CLK_KHZ) / 1000)

// ahb encodings
`define AIMX_HTRANS_NONSEQ 2'h2
`define AIMX_HTRANS_SEQ 2'h3

`endif

// ==== design/aimx_mux_decode.v ====
// registered decoder from the six-bit input code to analog switch enables
// assumes the code is stable in the cycle it is sampled; outputs lag by one edge
`timescale 1ns/1ns
`default_nettype none
`include "aimx_consts.vh"

module aimx_mux_decode
(
   input wire clk_in,
   input wire rst_in,
   input wire [5:0] code_in,
   output reg [11:0] pos_en_out,
   output reg [11:0] neg_en_out,
   output reg [3:0] int_src_out,
   output reg diff_out
);

   reg [3:0] pos_next;
   reg [3:0] neg_next;
   reg pos_valid;
   reg diff_next;
   reg [3:0] int_next;
   reg [7:0] pair;
   wire [11:0] pos_oh;
   wire [11:0] neg_oh;
   genvar i;

   // fixed pair table for the 01/11 groups: {positive, negative}
   function [7:0] pair_lut;
      input [3:0] idx;
      begin
         case (idx)
            4'h0: pair_lut = 8'h01;
            4'h1: pair_lut = 8'h03;
            4'h2: pair_lut = 8'h12;
            4'h3: pair_lut = 8'h13;
            4'h4: pair_lut = 8'h23;
            4'h5: pair_lut = 8'h34;
            4'h6: pair_lut = 8'h35;
            4'h7: pair_lut = 8'h36;
            4'h8: pair_lut = 8'h37;
            4'h9: pair_lut = 8'h45;
            4'hA: pair_lut = 8'h46;
            4'hB: pair_lut = 8'h47;
            4'hC: pair_lut = 8'h56;
            4'hD: pair_lut = 8'h57;
            4'hE: pair_lut = 8'h67;
            default: pair_lut = 8'h89;
         endcase
      end
   endfunction

   // code to pin numbers and internal source
   always @*
   begin
      pair = pair_lut(code_in[3:0]);
      pos_next = 4'h0;
      neg_next = 4'h0;
      pos_valid = 1'b0;
      diff_next = 1'b0;
      int_next = 4'h0;
      case (code_in[5:4])
         `AIMX_GRP_SINGLE:
         begin
            if (code_in[3:0] <= `AIMX_LAST_PIN)
            begin
               pos_next = code_in[3:0];
               pos_valid = 1'b1;
            end
            else
               int_next = 4'h1 << (code_in[3:0] - 4'hC); // temp, ref, ground, supply
         end
         `AIMX_GRP_DIFF:
         begin
            pos_next = pair[7:4];
            neg_next = pair[3:0];
            pos_valid = 1'b1;
            diff_next = 1'b1;
         end
         `AIMX_GRP_SWAP:
         begin
            pos_next = pair[3:0]; // polarity swapped
            neg_next = pair[7:4];
            pos_valid = 1'b1;
            diff_next = 1'b1;
         end
         default:
         begin
            if (code_in[3:0] <= `AIMX_SAME_LAST)
            begin
               pos_next = code_in[3:0]; // pin against itself
               neg_next = code_in[3:0];
               pos_valid = 1'b1;
               diff_next = 1'b1;
            end
            else if (code_in[3:0] <= `AIMX_SAME_HI_LAST)
            begin
               // bit 2 picks pin 10 or 11, bit 0 picks pin 8 or 9
               pos_next = {3'h5, code_in[2]}; // 10 or 11 against 8 or 9
               neg_next = {3'h4, code_in[0]};
               pos_valid = 1'b1;
               diff_next = 1'b1;
            end
         end
      endcase
   end

   // one-hot switch enables, one per pin
   generate
      for (i = 0; i < 12; i = i + 1)
      begin : g_pin
         assign pos_oh[i] = pos_valid && ({28'h0000000, pos_next} == i);
         assign neg_oh[i] = diff_next && ({28'h0000000, neg_next} == i);
      end
   endgenerate

   // registered outputs; all switches open in reset
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         pos_en_out <= 12'h000;
         neg_en_out <= 12'h000;
         int_src_out <= 4'h0;
         diff_out <= 1'b0;
      end
      else
      begin
         pos_en_out <= pos_oh;
         neg_en_out <= neg_oh;
         int_src_out <= int_next;
         diff_out <= diff_next;
      end
   end

endmodule // aimx_mux_decode

`default_nettype wire

// ==== design/aimx_top.v ====
// converter control slice: input select, deferred switching, result format
// assumes an ahb-lite master on one 20 MHz clock and a converter core with
// a start pulse, a done pulse and an 11-bit signed raw sample
// limits: single conversions only, no auto trigger, one conversion at a time
// gain code 3 is reserved and behaves as unity; the register map is this block's own
//
// Operation
// - differential result is ten-bit two's complement, -512 to +511.
// - differential result is scaled raw difference times selected gain, sign kept.
// - six-bit select field in bits 5:0; codes 0 to 11 pick pins.
// - codes 12 to 15 pick temperature, 1.1V reference, ground, supply.
// - 01/11 codes pick table pairs, 11 swapped; 10 codes pick fixed pairs; here group-10 codes 14 and 15 pick no pins.
// - a select written mid-conversion takes effect only after completion.
// - done flag rises when conversion ends and result is stored.
// - single-ended result is unsigned ten-bit, zero to reference minus one step.
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "aimx_consts.vh"

module aimx_top
#(
   parameter SETTLE_CYCLES = `AIMX_SETTLE_CYC
)
(
   input wire REF_CLK_IN,
   input wire RST_IN,
   input wire HSEL_IN,
   input wire [31:0] HADDR_IN,
   input wire [1:0] HTRANS_IN,
   input wire HWRITE_IN,
   input wire [2:0] HSIZE_IN,
   input wire [31:0] HWDATA_IN,
   input wire HREADY_IN,
   output wire HREADYOUT_OUT,
   output wire HRESP_OUT,
   output reg [31:0] HRDATA_OUT,
   input wire CONV_DONE_IN,
   input wire [10:0] CONV_DATA_IN,
   output reg CONV_START_OUT,
   output wire CONV_EN_OUT,
   output wire INT_REF_OUT,
   output wire [1:0] GAIN_SEL_OUT,
   output wire [11:0] POS_PIN_EN_OUT,
   output wire [11:0] NEG_PIN_EN_OUT,
   output wire [3:0] INT_SRC_OUT,
   output wire DIFF_MODE_OUT
);

   // software registers
   reg [5:0] input_select_field_reg;
   reg [5:0] active_sel_reg;
   reg conv_en_reg;
   reg int_ref_reg;
   reg [1:0] gain_reg;
   reg conversion_done_flag_reg;
   reg busy_reg;
   reg [9:0] result_reg;
   reg [15:0] settle_cnt_reg;
   reg settled_reg;

   // bus data-phase state
   reg wr_pend_reg;
   reg [7:0] wr_addr_reg;

   // next values
   reg [9:0] result_next;
   reg [31:0] rdata_next;
   reg [6:0] gain_val;
   wire addr_phase;
   wire wr_data;
   wire start_req;
   wire done_evt;
   wire clear_done;
   wire diff_sel;
   wire temp_ok;
   wire signed [10:0] raw_s;
   wire signed [18:0] prod_s;

   // last count of the settling timer, cut to the counter width on purpose;
   // a setting above 65536 cycles would need a wider counter
   localparam [31:0] SETTLE_FULL = SETTLE_CYCLES - 1;
   localparam [15:0] SETTLE_LAST = SETTLE_FULL[15:0];

   // offset match used by every write path
   function reg_hit;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         reg_hit = (addr == ofs);
      end
   endfunction

   // zero-wait slave: every transfer completes with okay
   assign HREADYOUT_OUT = 1'b1;
   assign HRESP_OUT = 1'b0;

   assign addr_phase = HSEL_IN && HREADY_IN && (HTRANS_IN == `AIMX_HTRANS_NONSEQ || HTRANS_IN == `AIMX_HTRANS_SEQ);
   // a write stays pending from its address phase until its data phase completes
   assign wr_data = wr_pend_reg && HREADY_IN;

   // control writes land in the data phase
   // a start needs enable already on, so the core is never kicked while powering up
   assign start_req = wr_data && reg_hit(wr_addr_reg, `AIMX_OFS_CTRL) && HWDATA_IN[`AIMX_CTRL_START]
                      && conv_en_reg && HWDATA_IN[`AIMX_CTRL_EN] && !busy_reg;
   assign clear_done = wr_data && reg_hit(wr_addr_reg, `AIMX_OFS_CTRL) && HWDATA_IN[`AIMX_CTRL_DONE];
   assign done_evt = busy_reg && CONV_DONE_IN;

   assign CONV_EN_OUT = conv_en_reg;
   assign INT_REF_OUT = int_ref_reg;
   assign GAIN_SEL_OUT = gain_reg;
   assign diff_sel = (active_sel_reg[5:4] != `AIMX_GRP_SINGLE);

   // temperature setup is software's job; this bit only reports whether it holds
   assign temp_ok = (active_sel_reg == `AIMX_CODE_TEMP) && int_ref_reg && settled_reg;

   // address phase capture; read data is latched here so hrdata is a flop
   always @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         HRDATA_OUT <= 32'h00000000;
      end
      else
      begin
         if (HREADY_IN)
         begin
            wr_pend_reg <= addr_phase && HWRITE_IN;
            wr_addr_reg <= HADDR_IN[7:0];
         end
         if (addr_phase && !HWRITE_IN)
            HRDATA_OUT <= rdata_next;
      end
   end

   // read decode; unmapped addresses read zero
   // the value is taken at the address phase, so a write just before is not yet seen
   always @*
   begin
      rdata_next = 32'h00000000;
      case (HADDR_IN[7:0])
         `AIMX_OFS_SEL:
            rdata_next[5:0] = input_select_field_reg;
         `AIMX_OFS_CTRL:
         begin
            rdata_next[`AIMX_CTRL_START] = busy_reg;
            rdata_next[`AIMX_CTRL_DONE] = conversion_done_flag_reg;
            rdata_next[`AIMX_CTRL_EN] = conv_en_reg;
            rdata_next[`AIMX_CTRL_IREF] = int_ref_reg;
            rdata_next[`AIMX_CTRL_GAIN_HI:`AIMX_CTRL_GAIN_LO] = gain_reg;
         end
         `AIMX_OFS_RESULT:
            rdata_next[9:0] = result_reg;
         `AIMX_OFS_STATUS:
         begin
            rdata_next[5:0] = active_sel_reg;
            rdata_next[`AIMX_STAT_BUSY] = busy_reg;
            rdata_next[`AIMX_STAT_SETTLED] = settled_reg;
            rdata_next[`AIMX_STAT_DIFF] = diff_sel;
            rdata_next[`AIMX_STAT_TEMP_OK] = temp_ok;
         end
         default:
            rdata_next = 32'h00000000;
      endcase
   end

   // register writes; byte lanes ignored since only whole words are issued
   always @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         input_select_field_reg <= `AIMX_SEL_RST;
         conv_en_reg <= 1'b0;
         int_ref_reg <= 1'b0;
         gain_reg <= 2'h0;
      end
      else if (wr_data)
      begin
         if (reg_hit(wr_addr_reg, `AIMX_OFS_SEL))
            input_select_field_reg <= HWDATA_IN[5:0];
         if (reg_hit(wr_addr_reg, `AIMX_OFS_CTRL))
         begin
            conv_en_reg <= HWDATA_IN[`AIMX_CTRL_EN];
            int_ref_reg <= HWDATA_IN[`AIMX_CTRL_IREF];
            gain_reg <= HWDATA_IN[`AIMX_CTRL_GAIN_HI:`AIMX_CTRL_GAIN_LO];
         end
      end
   end

   // conversion sequence: idle tracks the field, busy freezes it until done
   always @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         busy_reg <= 1'b0;
         CONV_START_OUT <= 1'b0;
         active_sel_reg <= `AIMX_SEL_RST;
      end
      else
      begin
         CONV_START_OUT <= start_req;
         if (!conv_en_reg)
            busy_reg <= 1'b0; // switching off aborts a running conversion
         else if (start_req)
            busy_reg <= 1'b1;
         else if (done_evt)
            busy_reg <= 1'b0;
         // reload at done so a select written mid-run serves the next start
         if (!busy_reg || done_evt)
            active_sel_reg <= input_select_field_reg; // held while busy
      end
   end

   // gain as a number; the reserved code falls back to unity
   always @*
   begin
      case (gain_reg)
         2'h1: gain_val = `AIMX_GAIN_X20;
         2'h2: gain_val = `AIMX_GAIN_X100;
         default: gain_val = `AIMX_GAIN_X1;
      endcase
   end

   // the raw sample is signed; single-ended codes read it as unsigned below
   assign raw_s = CONV_DATA_IN;
   assign prod_s = raw_s * $signed({1'b0, gain_val}); // difference times gain

   // result formatting; saturate rather than wrap so overrange keeps its sign
   always @*
   begin
      if (diff_sel)
      begin
         if (prod_s > 19'sd511)
            result_next = `AIMX_DIFF_MAX;
         else if (prod_s < -19'sd512)
            result_next = `AIMX_DIFF_MIN;
         else
            result_next = prod_s[9:0]; // two's complement kept
      end
      else if (CONV_DATA_IN[10])
         result_next = `AIMX_SE_MAX; // overrange clamps to full scale
      else
         result_next = CONV_DATA_IN[9:0]; // unsigned straight code
   end

   // result store and done flag; a new completion beats a same-cycle clear
   always @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         result_reg <= 10'h000;
         conversion_done_flag_reg <= 1'b0;
      end
      else
      begin
         if (done_evt)
         begin
            result_reg <= result_next;
            conversion_done_flag_reg <= 1'b1; // set with the result
         end
         else if (clear_done)
            conversion_done_flag_reg <= 1'b0;
      end
   end

   // reference settling timer; restarts whenever the reference or enable drops
   // even a one-cycle drop of either bit costs the full wait again
   always @(posedge REF_CLK_IN)
   begin
      if (RST_IN)
      begin
         settle_cnt_reg <= 16'h0000;
         settled_reg <= 1'b0;
      end
      else if (!conv_en_reg || !int_ref_reg)
      begin
         settle_cnt_reg <= 16'h0000;
         settled_reg <= 1'b0;
      end
      else if (settle_cnt_reg == SETTLE_LAST)
         settled_reg <= 1'b1;
      else
         settle_cnt_reg <= settle_cnt_reg + 16'h0001;
   end

   // switch decoder works from the held selection, never the raw field
   // its outputs lag the held selection by one edge
   aimx_mux_decode u_dec
   (
      .clk_in(REF_CLK_IN),
      .rst_in(RST_IN),
      .code_in(active_sel_reg),
      .pos_en_out(POS_PIN_EN_OUT),
      .neg_en_out(NEG_PIN_EN_OUT),
      .int_src_out(INT_SRC_OUT),
      .diff_out(DIFF_MODE_OUT)
   );

endmodule // aimx_top

`default_nettype wire

// ==== bench/aimx_props.sv ====
// checker for the converter slice: switch enables and the start/done link
// assumes it is bound to aimx_top and sees only that module's ports
`timescale 1ns/1ns
`default_nettype none
module aimx_props
(
   input wire REF_CLK_IN,
   input wire RST_IN,
   input wire CONV_DONE_IN,
   input wire CONV_START_OUT,
   input wire CONV_EN_OUT,
   input wire [11:0] POS_PIN_EN_OUT,
   input wire [11:0] NEG_PIN_EN_OUT,
   input wire [3:0] INT_SRC_OUT,
   input wire DIFF_MODE_OUT
);
   default clocking dc @(posedge REF_CLK_IN); endclocking
   default disable iff (RST_IN);
   reg busy_reg;
   // running conversion: start pulse until done or an enable drop aborts it
   always @(posedge REF_CLK_IN)
   begin
      if (RST_IN || CONV_DONE_IN || !CONV_EN_OUT)
         busy_reg <= 1'b0;
      else if (CONV_START_OUT)
         busy_reg <= 1'b1;
   end
   property p_pos_one; $onehot0(POS_PIN_EN_OUT); endproperty
   a_pos_one: assert property (p_pos_one) else $error("positive switch not one-hot");
   property p_int_one; $onehot0(INT_SRC_OUT); endproperty
   a_int_one: assert property (p_int_one) else $error("internal source not one-hot");
   property p_int_alone; |INT_SRC_OUT |-> !POS_PIN_EN_OUT && !NEG_PIN_EN_OUT && !DIFF_MODE_OUT; endproperty
   a_int_alone: assert property (p_int_alone) else $error("internal source shares a pin");
   property p_neg_diff; |NEG_PIN_EN_OUT |-> DIFF_MODE_OUT && $onehot(POS_PIN_EN_OUT); endproperty
   a_neg_diff: assert property (p_neg_diff) else $error("negative pin outside a pair");
   property p_diff_pair; DIFF_MODE_OUT && |POS_PIN_EN_OUT |-> $onehot(NEG_PIN_EN_OUT); endproperty
   a_diff_pair: assert property (p_diff_pair) else $error("pair lacks negative pin");
   property p_frozen;
      busy_reg && !CONV_DONE_IN && CONV_EN_OUT |=>
         $stable(POS_PIN_EN_OUT) && $stable(NEG_PIN_EN_OUT) && $stable(INT_SRC_OUT);
   endproperty
   a_frozen: assert property (p_frozen) else $error("switches moved mid-conversion");
   property p_no_restart; busy_reg |-> !CONV_START_OUT; endproperty
   a_no_restart: assert property (p_no_restart) else $error("start while busy");
   property p_start_en; CONV_START_OUT |-> CONV_EN_OUT ##1 !CONV_START_OUT; endproperty
   a_start_en: assert property (p_start_en) else $error("bad start pulse");
endmodule // aimx_props
bind aimx_top aimx_props chk (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .CONV_DONE_IN(CONV_DONE_IN),
   .CONV_START_OUT(CONV_START_OUT), .CONV_EN_OUT(CONV_EN_OUT), .POS_PIN_EN_OUT(POS_PIN_EN_OUT),
   .NEG_PIN_EN_OUT(NEG_PIN_EN_OUT), .INT_SRC_OUT(INT_SRC_OUT), .DIFF_MODE_OUT(DIFF_MODE_OUT));
`default_nettype wire

// ==== bench/aimx_core_model.sv ====
// behavioural converter core: answers a start pulse after a set delay
// assumes start is a one-cycle pulse and enable a level
`timescale 1ns/1ns
`default_nettype none
module aimx_core_model
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire logic en_in,
   input wire logic [7:0] delay_in,
   input wire logic [10:0] sample_in,
   output logic done_out,
   output logic [10:0] data_out
);
   logic [7:0] cnt_reg;
   // data only valid with done; otherwise it toggles so stale values never match
   always @(posedge clk_in)
   begin
      done_out <= 1'b0;
      data_out <= rst_in ? 11'h555 : ~data_out;
      if (rst_in || !en_in)
         cnt_reg <= 8'h00; // a disabled core drops its conversion
      else if (start_in)
         cnt_reg <= delay_in;
      else if (cnt_reg == 8'h01)
      begin
         cnt_reg <= 8'h00;
         done_out <= 1'b1;
         data_out <= sample_in;
      end
      else if (cnt_reg != 8'h00)
         cnt_reg <= cnt_reg - 8'h01;
   end
endmodule // aimx_core_model
`default_nettype wire

// ==== bench/aimx_top_bench.sv ====
// self-checking bench for aimx_top: ahb-lite master, core model, mux table
// assumes the checker is bound by its own file
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module aimx_top_bench;
   localparam int SETTLE = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   wire hready, hresp, done, start, en, iref, diff;
   wire [10:0] cdata;
   wire [1:0] gsel;
   wire [11:0] pos, neg;
   wire [3:0] isrc;
   logic [7:0] dly = 8'h1E;
   logic [10:0] smp = 11'h000;
   int num_errors = 0;
   int total_checks = 0;
   int seed = 32'hA5C8;
   aimx_top #(.SETTLE_CYCLES(SETTLE)) uut (.REF_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
      .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .HRDATA_OUT(hrdata), .CONV_DONE_IN(done),
      .CONV_DATA_IN(cdata), .CONV_START_OUT(start), .CONV_EN_OUT(en), .INT_REF_OUT(iref),
      .GAIN_SEL_OUT(gsel), .POS_PIN_EN_OUT(pos), .NEG_PIN_EN_OUT(neg), .INT_SRC_OUT(isrc),
      .DIFF_MODE_OUT(diff));
   aimx_core_model core (.clk_in(clk), .rst_in(rst), .start_in(start), .en_in(en), .delay_in(dly),
      .sample_in(smp), .done_out(done), .data_out(cdata));
   // free-running 20 MHz clock
   initial
   begin
      forever #25 clk = ~clk;
   end
   // one single ahb-lite transfer; read data taken at the data-phase edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      hwrite <= w;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // expected {pos, neg, int, diff}; the two empty codes get diff forced here and in seen
   function automatic logic [28:0] emux(input logic [5:0] c);
      int p, n;
      int dp[16] = '{0, 0, 1, 1, 2, 3, 3, 3, 3, 4, 4, 4, 5, 5, 6, 8};
      int dn[16] = '{1, 3, 2, 3, 3, 4, 5, 6, 7, 5, 6, 7, 6, 7, 7, 9};
      emux = 29'h0;
      p = c[5:4] == 2'h2 ? (c[3:0] < 10 ? c[3:0] : 10 + (c[3:0] - 10) / 2) : dp[c[3:0]];
      n = c[5:4] == 2'h2 ? (c[3:0] < 10 ? c[3:0] : 8 + c[0]) : dn[c[3:0]];
      if (c < 6'h0C)
         emux[28:17] = 12'h001 << c;
      else if (c < 6'h10)
         emux[4:1] = 4'h1 << (c - 6'h0C);
      else if (c == 6'h2E || c == 6'h2F)
         emux[0] = 1'b1;
      else
         emux = {12'h001 << (c[5:4] == 2'h3 ? n : p), 12'h001 << (c[5:4] == 2'h3 ? p : n), 4'h0, 1'b1};
   endfunction
   function automatic logic [28:0] seen(input logic [5:0] c);
      seen = {pos, neg, isrc, diff | (c == 6'h2E || c == 6'h2F)};
   endfunction
   // start a conversion on code c with gain g, change the select mid-way, check all
   task automatic convert(input int i, input logic [5:0] c, input logic [1:0] g);
      logic [5:0] c2;
      logic [9:0] e;
      int v;
      int gn[4] = '{1, 20, 100, 1};
      logic [10:0] raws[4] = '{11'h400, 11'h600, 11'h3FF, 11'h200};
      c2 = $random(seed);
      smp <= i < 4 ? raws[i] : 11'($random(seed));
      bus(1'b1, 8'h00, {26'h0, c});
      bus(1'b1, 8'h04, {26'h0, g, 4'h5});
      bus(1'b1, 8'h00, {26'h0, c2});
      #1 `CHK("held_mux", emux(c), seen(c))
      bus(1'b0, 8'h0C, 32'h0);
      `CHK("held_sel", c, rd[5:0])
      `CHK("gain_pin", g, gsel)
      repeat (40)
      begin
         bus(1'b0, 8'h04, 32'h0);
         if (rd[0] === 1'b0)
            break;
      end
      `CHK("done_flag", 2'h2, rd[1:0])
      bus(1'b0, 8'h08, 32'h0);
      v = $signed(smp) * gn[g];
      v = v > 511 ? 511 : (v < -512 ? -512 : v);
      e = c < 6'h10 ? (smp[10] ? 10'h3FF : smp[9:0]) : v[9:0];
      `CHK("result", {22'h0, e}, rd)
      bus(1'b1, 8'h04, {26'h0, g, 4'h6});
      #1 `CHK("new_mux", emux(c2), seen(c2))
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // watchdog well beyond the fewer than two thousand cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      results();
   end
   // main sequence
   initial
   begin
      logic [5:0] c;
      logic [31:0] r;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 8'h00, 32'h0);
      `CHK("sel_rst", 32'h0, rd)
      `CHK("mux_rst", emux(6'h00), seen(6'h00))
      for (int k = 0; k < 64; k++)
      begin
         r = $random(seed);
         bus(1'b1, 8'h00, {r[31:6], 6'(k)});
         repeat (2) @(posedge clk);
         #1 `CHK("mux", emux(6'(k)), seen(6'(k)))
         bus(1'b0, 8'h00, 32'h0);
         `CHK("sel", 32'(k), rd)
      end
      $display("mux table test done");
      bus(1'b1, 8'h10, 32'hFFFF);
      bus(1'b0, 8'h10, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      `CHK("hresp", 1'b0, hresp)
      // temperature setup: sensor channel and internal reference, then the wait
      bus(1'b1, 8'h00, 32'h0C);
      bus(1'b1, 8'h04, 32'h0C);
      bus(1'b0, 8'h0C, 32'h0);
      `CHK("unsettled", 2'h0, {rd[9], rd[7]})
      `CHK("iref_pin", 1'b1, iref)
      repeat (SETTLE) @(posedge clk);
      bus(1'b0, 8'h0C, 32'h0);
      `CHK("settled", 3'h5, rd[9:7])
      $display("settle test done");
      for (int i = 0; i < 16; i++)
      begin
         r = $random(seed);
         c = i % 2 ? {r[4] ? 2'h3 : 2'h1, r[3:0]} : 6'(r[7:0] % 12);
         convert(i, c, 2'(i / 4));
      end
      $display("conversion test done");
      results();
   end
endmodule // aimx_top_bench
`default_nettype wire
